// ---- verilog/svmfoc_defs.vh ----
// Constants for the field-oriented control and space vector modulation datapath.
`ifndef SVMFOC_DEFS_VH
`define SVMFOC_DEFS_VH

// Register byte offsets on the APB.
`define SVMFOC_A_CTRL    8'h00
`define SVMFOC_A_STAT    8'h04
`define SVMFOC_A_PERIOD  8'h08
`define SVMFOC_A_VDC     8'h0c
`define SVMFOC_A_ANGLE   8'h10
`define SVMFOC_A_VDQ     8'h14
`define SVMFOC_A_POLAR   8'h18
`define SVMFOC_A_IDQ     8'h1c
`define SVMFOC_A_IAB     8'h20
`define SVMFOC_A_VAB     8'h24
`define SVMFOC_A_T12     8'h28
`define SVMFOC_A_T0      8'h2c
`define SVMFOC_A_DUTY_UV 8'h30
`define SVMFOC_A_DUTY_W  8'h34

// Control register fields.
`define SVMFOC_B_SEVEN 0
`define SVMFOC_B_POLAR 1
`define SVMFOC_B_QSTD  2
`define SVMFOC_B_START 3
`define SVMFOC_B_AUTO  4

// Reset values.
`define SVMFOC_CTRL_RST   5'h01
`define SVMFOC_PERIOD_RST 16'h03e8
`define SVMFOC_VDC_RST    16'h0100

// Fixed-point constants, Q14 unless noted.
`define SVMFOC_SIN60      16'h376d
`define SVMFOC_HALF       16'h2000
`define SVMFOC_ONE        16'h4000
`define SVMFOC_INVSQ3     16'h24f3
`define SVMFOC_TWO_INVSQ3 16'h49e6
`define SVMFOC_SQRT3      16'h6eda
`define SVMFOC_SMAX       34'sh0_0000_7fff
`define SVMFOC_SMIN       34'sh3_ffff_8000

// Angle constants, full circle is 16'h10000.
`define SVMFOC_QUARTER 16'h4000
`define SVMFOC_SIXTH   16'h2aab
`define SVMFOC_SEC2    16'h5555
`define SVMFOC_SEC3    16'h8000
`define SVMFOC_SEC4    16'haaab
`define SVMFOC_SEC5    16'hd555

// Null vectors, upper switches U V W, MSB is U.
`define SVMFOC_ZERO_LO 3'h0
`define SVMFOC_ZERO_HI 3'h7

// Divider timing count.
`define SVMFOC_DIV_LAST 6'h1f

`endif

// ---- verilog/svmfoc_datapath.v ----
// Coordinate transforms and space vector timing datapath with an APB register file.
//
// How it works
// - Switch codes give upper bits only; lowers are complements, so no leg shoots through.
// - Six active upper-switch codes, one per sector boundary, all non-null.
// - Codes 000 and 111 are null vectors producing no field.
// - Plane split into sectors A..F, each between two adjacent active vectors.
// - Phase voltage model is Vdc/3 times (2,-1,-1) weighted switch bits.
// - Relative angle is absolute angle minus first vector angle of sector.
// - First, second and zero times follow the sine timing equations.
// - Both active vectors and zero vector applied for computed durations.
// - Per-phase duty is output every computation period.
// - Control bit selects seven- or five-segment pattern.
// - Five-segment uses the same timing equations, only arrangement differs.
// - Five-segment uses only the all-lower zero vector.
// - Seven-segment shares zero time between both null vectors.
// - Alpha equals phase U; beta is (U plus twice V) over root three.
// - Balanced currents assumed; phase W is never sampled.
// - Rotor-frame d from alpha cos plus beta sin; q sign selectable.
// - Inverse rotation gives alpha and beta from d, q and the angle.
// - Inverse rotation output drives the modulator without inverse three-phase stage.
// - Optional polar magnitude and angle input path to the modulator.
`timescale 1ns/10ps
`include "svmfoc_defs.vh"

module svmfoc_datapath (
  input  wire        clk_sys,
  input  wire        rst,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        adc_valid,
  input  wire [15:0] adc_iu,
  input  wire [15:0] adc_iv,
  output reg  [15:0] duty_u,
  output reg  [15:0] duty_v,
  output reg  [15:0] duty_w,
  output reg         duty_valid,
  output reg  [2:0]  sw_first,
  output reg  [2:0]  sw_second,
  output reg  [2:0]  sector
);

  localparam [2:0] S_IDLE = 3'h0;
  localparam [2:0] S_CLK  = 3'h1;
  localparam [2:0] S_PARK = 3'h2;
  localparam [2:0] S_SECT = 3'h3;
  localparam [2:0] S_DIV  = 3'h4;
  localparam [2:0] S_TIME = 3'h5;
  localparam [2:0] S_OUT  = 3'h6;

  // Saturate a wide signed value to 16 bits.
  function signed [15:0] sat16;
    input signed [33:0] x;
    begin
      if (x > `SVMFOC_SMAX)
        sat16 = 16'h7fff;
      else if (x < `SVMFOC_SMIN)
        sat16 = 16'h8000;
      else
        sat16 = x[15:0];
    end
  endfunction

  // Q14 sum of two products, saturated; the wide sum avoids wrap on corners.
  function signed [15:0] ma2;
    input signed [15:0] a;
    input signed [15:0] b;
    input signed [15:0] c;
    input signed [15:0] d;
    reg signed [33:0] p;
    begin
      p = a * b + c * d;
      p = p >>> 14;
      ma2 = sat16(p);
    end
  endfunction

  // Coarse quarter-wave sine in Q14; 16 steps per quadrant trades accuracy for area.
  function signed [15:0] sinf;
    input [15:0] a;
    reg [3:0]  i;
    reg [14:0] m;
    begin
      i = a[14] ? ~a[13:10] : a[13:10];
      case (i)
        4'h0:    m = 15'h0000;
        4'h1:    m = 15'h0646;
        4'h2:    m = 15'h0c7c;
        4'h3:    m = 15'h1294;
        4'h4:    m = 15'h187e;
        4'h5:    m = 15'h1e2b;
        4'h6:    m = 15'h238e;
        4'h7:    m = 15'h289a;
        4'h8:    m = 15'h2d41;
        4'h9:    m = 15'h3179;
        4'ha:    m = 15'h3537;
        4'hb:    m = 15'h3871;
        4'hc:    m = 15'h3b21;
        4'hd:    m = 15'h3d3f;
        4'he:    m = 15'h3ec5;
        default: m = 15'h3fb1;
      endcase
      sinf = a[15] ? -$signed({1'b0, m}) : $signed({1'b0, m});
    end
  endfunction

  // Sine of the first vector angle of sector k.
  function signed [15:0] s60;
    input [2:0] k;
    begin
      case (k)
        3'h1, 3'h2: s60 = `SVMFOC_SIN60;
        3'h4, 3'h5: s60 = -`SVMFOC_SIN60;
        default:    s60 = 16'h0000;
      endcase
    end
  endfunction

  // Cosine of the first vector angle of sector k.
  function signed [15:0] c60;
    input [2:0] k;
    begin
      case (k)
        3'h0:       c60 = `SVMFOC_ONE;
        3'h1, 3'h5: c60 = `SVMFOC_HALF;
        3'h3:       c60 = -`SVMFOC_ONE;
        default:    c60 = -`SVMFOC_HALF;
      endcase
    end
  endfunction

  // Next sector index, wrapping F back to A.
  function [2:0] nx;
    input [2:0] k;
    begin
      nx = (k == 3'h5) ? 3'h0 : k + 3'h1;
    end
  endfunction

  // Upper-switch code of the active vector at the start of sector k.
  function [2:0] vcode;
    input [2:0] k;
    begin
      case (k)
        3'h0:    vcode = 3'b100;
        3'h1:    vcode = 3'b110;
        3'h2:    vcode = 3'b010;
        3'h3:    vcode = 3'b011;
        3'h4:    vcode = 3'b001;
        default: vcode = 3'b101;
      endcase
    end
  endfunction

  // Phase voltage in units of Vdc/3 for a switch state, range -2..2.
  function [2:0] vph;
    input s;
    input o1;
    input o2;
    begin
      vph = {1'b0, s, 1'b0} - {2'b00, o1} - {2'b00, o2};
    end
  endfunction

  // High-side on-time of a phase from its bit in the two active vectors.
  function [15:0] pdur;
    input        b1;
    input        b2;
    input [15:0] t1;
    input [15:0] t2;
    input [15:0] z;
    begin
      if (b1 && b2)
        pdur = t1 + t2 + z;
      else if (b1)
        pdur = t1 + z;
      else if (b2)
        pdur = t2 + z;
      else
        pdur = z;
    end
  endfunction

  reg [4:0]         ctrl_r;
  reg               start_r;
  reg [2:0]         st_r;
  reg [15:0]        per_r;
  reg [15:0]        vdc_r;
  reg [15:0]        ang_r;
  reg signed [15:0] vd_r;
  reg signed [15:0] vq_r;
  reg signed [15:0] mag_r;
  reg [15:0]        pang_r;
  reg signed [15:0] iu_r;
  reg signed [15:0] iv_r;
  reg signed [15:0] ia_r;
  reg signed [15:0] ib_r;
  reg signed [15:0] id_r;
  reg signed [15:0] iq_r;
  reg signed [15:0] va_r;
  reg signed [15:0] vb_r;
  reg [15:0]        x1_r;
  reg [15:0]        x2_r;
  reg [31:0]        num_r;
  reg [16:0]        rem_r;
  reg [5:0]         cnt_r;
  reg [15:0]        t1_r;
  reg [15:0]        t2_r;
  reg [15:0]        t0_r;

  wire       wr_en  = psel & penable & pwrite;
  wire       go     = start_r | (ctrl_r[`SVMFOC_B_AUTO] & adc_valid);
  wire       busy   = (st_r != S_IDLE);
  wire [2:0] first  = vcode(sector);
  wire [2:0] second = vcode(nx(sector));

  // The slave never stalls; unmapped addresses answer with an error.
  reg mapped;
  always @* begin
    case (paddr)
      `SVMFOC_A_CTRL, `SVMFOC_A_STAT, `SVMFOC_A_PERIOD, `SVMFOC_A_VDC,
      `SVMFOC_A_ANGLE, `SVMFOC_A_VDQ, `SVMFOC_A_POLAR, `SVMFOC_A_IDQ,
      `SVMFOC_A_IAB, `SVMFOC_A_VAB, `SVMFOC_A_T12, `SVMFOC_A_T0,
      `SVMFOC_A_DUTY_UV, `SVMFOC_A_DUTY_W: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  // Rotor angle sine and cosine, shared by both rotations.
  wire signed [15:0] sn = sinf(ang_r);
  wire signed [15:0] cs = sinf(ang_r + `SVMFOC_QUARTER);

  // Sector search and the two scaled sine terms for the active selected path.
  reg [2:0]         k_c;
  reg [15:0]        pa_c;
  reg [15:0]        rel_c;
  reg signed [15:0] u_c;
  reg signed [15:0] x1_c;
  reg signed [15:0] x2_c;
  always @* begin
    pa_c  = ang_r + pang_r;
    u_c   = ma2(va_r, `SVMFOC_SQRT3, 16'h0000, 16'h0000);
    rel_c = 16'h0000;
    if (ctrl_r[`SVMFOC_B_POLAR]) begin
      if (pa_c < `SVMFOC_SIXTH) begin
        k_c = 3'h0;
        rel_c = pa_c;
      end else if (pa_c < `SVMFOC_SEC2) begin
        k_c = 3'h1;
        rel_c = pa_c - `SVMFOC_SIXTH;
      end else if (pa_c < `SVMFOC_SEC3) begin
        k_c = 3'h2;
        rel_c = pa_c - `SVMFOC_SEC2;
      end else if (pa_c < `SVMFOC_SEC4) begin
        k_c = 3'h3;
        rel_c = pa_c - `SVMFOC_SEC3;
      end else if (pa_c < `SVMFOC_SEC5) begin
        k_c = 3'h4;
        rel_c = pa_c - `SVMFOC_SEC4;
      end else begin
        k_c = 3'h5;
        rel_c = pa_c - `SVMFOC_SEC5;
      end
      // Magnitude times sine of remainder and of its complement to 60 degrees.
      x2_c = ma2(mag_r, sinf(rel_c), 16'h0000, 16'h0000);
      x1_c = ma2(mag_r, sinf(`SVMFOC_SIXTH - rel_c), 16'h0000, 16'h0000);
    end else begin
      // Sign tests against root-three alpha pick the 60-degree range.
      if (!vb_r[15])
        k_c = (vb_r < u_c) ? 3'h0 : ((vb_r < -u_c) ? 3'h2 : 3'h1);
      else
        k_c = (vb_r > -u_c) ? 3'h5 : ((vb_r > u_c) ? 3'h3 : 3'h4);
      // Rotating by minus the sector start gives the relative-angle sines.
      x2_c = ma2(vb_r, c60(k_c), va_r, -s60(k_c));
      x1_c = ma2(va_r, s60(nx(k_c)), vb_r, -c60(nx(k_c)));
    end
  end

  // Products of the period gain with each sine term, then clamping.
  wire [47:0] p1   = x1_r * num_r;
  wire [47:0] p2   = x2_r * num_r;
  // The gain carries 16 fraction bits; dropping them leaves whole clock counts.
  wire [31:0] t1w  = p1[47:16];
  wire [31:0] t2w  = p2[47:16];
  wire [15:0] t1s  = (t1w > {16'h0000, per_r}) ? per_r : t1w[15:0];
  wire [15:0] rest = per_r - t1s;
  wire [15:0] t2s  = (t2w > {16'h0000, rest}) ? rest : t2w[15:0];
  wire [16:0] trial = {rem_r[15:0], num_r[31]};
  wire        fits  = (trial >= {1'b0, vdc_r});

  // Seven-segment splits zero time over 000 and 111; five-segment keeps only 000.
  wire [15:0] zt = ctrl_r[`SVMFOC_B_SEVEN] ? {1'b0, t0_r[15:1]} : 16'h0000;

  // Register writes from the bus; the start bit is a self-clearing pulse.
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ctrl_r  <= `SVMFOC_CTRL_RST;
      start_r <= 1'b0;
      per_r   <= `SVMFOC_PERIOD_RST;
      vdc_r   <= `SVMFOC_VDC_RST;
      ang_r   <= 16'h0000;
      vd_r    <= 16'h0000;
      vq_r    <= 16'h0000;
      mag_r   <= 16'h0000;
      pang_r  <= 16'h0000;
    end else begin
      start_r <= 1'b0;
      if (wr_en) begin
        case (paddr)
          `SVMFOC_A_CTRL: begin
            ctrl_r  <= pwdata[4:0] & 5'h17;
            start_r <= pwdata[`SVMFOC_B_START];
          end
          `SVMFOC_A_PERIOD: per_r <= pwdata[15:0];
          `SVMFOC_A_VDC:    vdc_r <= pwdata[15:0];
          `SVMFOC_A_ANGLE:  ang_r <= pwdata[15:0];
          `SVMFOC_A_VDQ: begin
            vd_r <= pwdata[15:0];
            vq_r <= pwdata[31:16];
          end
          `SVMFOC_A_POLAR: begin
            mag_r  <= {1'b0, pwdata[14:0]};
            pang_r <= pwdata[31:16];
          end
          default: ;
        endcase
      end
    end
  end

  // Read data is captured in the setup cycle so it stands through the access phase.
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable) begin
      case (paddr)
        `SVMFOC_A_CTRL:    prdata <= {27'h0, ctrl_r};
        `SVMFOC_A_STAT:    prdata <= {13'h0, vph(first[0], first[2], first[1]),
                                      vph(first[1], first[2], first[0]),
                                      vph(first[2], first[1], first[0]),
                                      second, first, sector, busy};
        `SVMFOC_A_PERIOD:  prdata <= {16'h0, per_r};
        `SVMFOC_A_VDC:     prdata <= {16'h0, vdc_r};
        `SVMFOC_A_ANGLE:   prdata <= {16'h0, ang_r};
        `SVMFOC_A_VDQ:     prdata <= {vq_r, vd_r};
        `SVMFOC_A_POLAR:   prdata <= {pang_r, mag_r};
        `SVMFOC_A_IDQ:     prdata <= {iq_r, id_r};
        `SVMFOC_A_IAB:     prdata <= {ib_r, ia_r};
        `SVMFOC_A_VAB:     prdata <= {vb_r, va_r};
        `SVMFOC_A_T12:     prdata <= {t2_r, t1_r};
        `SVMFOC_A_T0:      prdata <= {16'h0, t0_r};
        `SVMFOC_A_DUTY_UV: prdata <= {duty_v, duty_u};
        `SVMFOC_A_DUTY_W:  prdata <= {16'h0, duty_w};
        default:           prdata <= 32'h0000_0000;
      endcase
    end
  end

  // Only U and V are sampled; W is implied by balanced currents.
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      iu_r <= 16'h0000;
      iv_r <= 16'h0000;
    end else if (adc_valid) begin
      iu_r <= adc_iu;
      iv_r <= adc_iv;
    end
  end

  // Computation sequencer; a start while busy is ignored.
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_r       <= S_IDLE;
      ia_r       <= 16'h0000;
      ib_r       <= 16'h0000;
      id_r       <= 16'h0000;
      iq_r       <= 16'h0000;
      va_r       <= 16'h0000;
      vb_r       <= 16'h0000;
      x1_r       <= 16'h0000;
      x2_r       <= 16'h0000;
      num_r      <= 32'h0000_0000;
      rem_r      <= 17'h00000;
      cnt_r      <= 6'h00;
      t1_r       <= 16'h0000;
      t2_r       <= 16'h0000;
      t0_r       <= 16'h0000;
      duty_u     <= 16'h0000;
      duty_v     <= 16'h0000;
      duty_w     <= 16'h0000;
      duty_valid <= 1'b0;
      sw_first   <= `SVMFOC_ZERO_LO;
      sw_second  <= `SVMFOC_ZERO_LO;
      sector     <= 3'h0;
    end else begin
      duty_valid <= 1'b0;
      case (st_r)
        S_IDLE: begin
          if (go)
            st_r <= S_CLK;
        end
        S_CLK: begin
          ia_r <= iu_r;
          ib_r <= ma2(iu_r, `SVMFOC_INVSQ3, iv_r, `SVMFOC_TWO_INVSQ3);
          st_r <= S_PARK;
        end
        S_PARK: begin
          id_r <= ma2(ia_r, cs, ib_r, sn);
          // Printed form adds both products; the QSTD bit restores the usual minus.
          iq_r <= ma2(ia_r, ctrl_r[`SVMFOC_B_QSTD] ? -sn : sn, ib_r, cs);
          va_r <= ma2(vd_r, cs, vq_r, -sn);
          vb_r <= ma2(vd_r, -sn, vq_r, cs);
          st_r <= S_SECT;
        end
        S_SECT: begin
          sector <= k_c;
          x1_r   <= x1_c[15] ? 16'h0000 : x1_c;
          x2_r   <= x2_c[15] ? 16'h0000 : x2_c;
          num_r  <= {per_r, 16'h0000};
          rem_r  <= 17'h00000;
          cnt_r  <= 6'h00;
          st_r   <= S_DIV;
        end
        S_DIV: begin
          // Restoring divide builds the period over Vdc gain one bit per cycle.
          rem_r <= fits ? trial - {1'b0, vdc_r} : trial;
          num_r <= {num_r[30:0], fits};
          cnt_r <= cnt_r + 6'h01;
          if (cnt_r == `SVMFOC_DIV_LAST)
            st_r <= S_TIME;
        end
        S_TIME: begin
          t1_r <= t1s;
          t2_r <= t2s;
          t0_r <= rest - t2s;
          st_r <= S_OUT;
        end
        S_OUT: begin
          duty_u     <= pdur(first[2], second[2], t1_r, t2_r, zt);
          duty_v     <= pdur(first[1], second[1], t1_r, t2_r, zt);
          duty_w     <= pdur(first[0], second[0], t1_r, t2_r, zt);
          sw_first   <= first;
          sw_second  <= second;
          duty_valid <= 1'b1;
          st_r       <= S_IDLE;
        end
        default: st_r <= S_IDLE;
      endcase
    end
  end

  // Null codes leave as active vectors only as the reset value of sw_first and sw_second; zero time is the timer's 000/111 span.
  // Zero codes are defined constants lowers are the complement of sw_first.

endmodule // svmfoc_datapath

// ---- sim/svmfoc_props.sv ----
// Concurrent checks on the ports of the transform and modulation datapath.
`timescale 1ns/10ps
module svmfoc_props (
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        adc_valid,
  input wire logic [15:0] adc_iu,
  input wire logic [15:0] adc_iv,
  input wire logic [15:0] duty_u,
  input wire logic [15:0] duty_v,
  input wire logic [15:0] duty_w,
  input wire logic        duty_valid,
  input wire logic [2:0]  sw_first,
  input wire logic [2:0]  sw_second,
  input wire logic [2:0]  sector
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);

  // Picks the duty of the single phase named by a one-hot code, zero otherwise.
  function automatic logic [15:0] pick(input logic [2:0] c, input logic [15:0] u, v, w);
    pick = (c == 3'h4) ? u : (c == 3'h2) ? v : (c == 3'h1) ? w : 16'h0000;
  endfunction

  // A start request is only made by the bench while the datapath is idle.
  sequence seq_start_wr;
    psel && penable && pwrite && (paddr == 8'h00) && pwdata[3];
  endsequence
  // The pipeline stays quiet for a while, then reports within a short window.
  sequence seq_compute;
    (!duty_valid) [*8] ##[30:32] duty_valid;
  endsequence

  chk_start_latency: assert property (seq_start_wr |=> seq_compute)
    else $error("duty report did not follow a start at the expected cycle");
  chk_valid_pulse: assert property (duty_valid |=> !duty_valid)
    else $error("duty report lasted more than one cycle");
  chk_null_free: assert property (duty_valid |->
    sw_first != 3'h0 && sw_first != 3'h7 && sw_second != 3'h0 && sw_second != 3'h7)
    else $error("active vector code is a null vector");
  chk_adjacent_pair: assert property (duty_valid |-> $onehot(sw_first ^ sw_second))
    else $error("sector vectors are not adjacent");
  chk_sector_range: assert property (duty_valid |-> sector <= 3'h5)
    else $error("sector outside A to F");
  // The sector register moves mid-computation, so the codes sent with the duties are held instead.
  chk_duty_hold: assert property (!duty_valid |-> $stable(duty_u) && $stable(duty_v) &&
    $stable(duty_w) && $stable(sw_first) && $stable(sw_second))
    else $error("duties changed without a report");
  chk_common_phase: assert property (duty_valid |->
    pick(sw_first & sw_second, duty_u, duty_v, duty_w) >=
    pick(~(sw_first | sw_second), duty_u, duty_v, duty_w))
    else $error("phase on in both vectors has less on-time than the idle phase");
  chk_unmapped_err: assert property (psel && penable && paddr > 8'h34 |-> pslverr)
    else $error("unmapped access not refused");
  chk_mapped_ok: assert property (psel && penable && paddr <= 8'h34 &&
    paddr[1:0] == 2'h0 |-> !pslverr && pready)
    else $error("mapped access refused or stalled");
endmodule // svmfoc_props

bind svmfoc_datapath svmfoc_props u_props (
  .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .adc_valid(adc_valid), .adc_iu(adc_iu), .adc_iv(adc_iv), .duty_u(duty_u),
  .duty_v(duty_v), .duty_w(duty_w), .duty_valid(duty_valid), .sw_first(sw_first),
  .sw_second(sw_second), .sector(sector)
);

// ---- sim/svmfoc_adc_model.sv ----
// Behavioural phase-current converter that feeds samples to the datapath.
`timescale 1ns/10ps
module svmfoc_adc_model (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        req,
  input  wire logic [15:0] iu_in,
  input  wire logic [15:0] iv_in,
  output logic             adc_valid,
  output logic [15:0]      adc_iu,
  output logic [15:0]      adc_iv
);
  logic conv_r;

  // One cycle of conversion, then a one-cycle valid; the data lines toggle
  // outside the valid cycle so a late capture cannot hit a stale sample.
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      conv_r    <= 1'b0;
      adc_valid <= 1'b0;
      adc_iu    <= 16'h0000;
      adc_iv    <= 16'h0000;
    end else begin
      conv_r    <= req;
      adc_valid <= conv_r;
      if (conv_r) begin
        adc_iu <= iu_in; // Only phases U and V are converted.
        adc_iv <= iv_in;
      end else begin
        adc_iu <= ~adc_iu;
        adc_iv <= ~adc_iv;
      end
    end
  end
endmodule // svmfoc_adc_model

// ---- sim/testbench.sv ----
// Self-checking bench for the transform and modulation datapath.
`timescale 1ns/10ps
`include "svmfoc_defs.vh"
`define CHK(a, b) begin n_tests = n_tests + 1; if ((a) !== (b)) begin num_errors = num_errors + 1; $display("CHECK FAILED at %0t: got %h expected %h", $time, (a), (b)); end end
module testbench;
  logic        clk_sys, rst, psel, penable, pwrite, adc_req, er;
  logic [7:0]  paddr;
  logic [31:0] pwdata, rd, t12, t12s, t0v;
  logic [15:0] iu_in, iv_in, z;
  wire  [31:0] prdata;
  wire         pready, pslverr, adc_valid, duty_valid;
  wire  [15:0] adc_iu, adc_iv, duty_u, duty_v, duty_w;
  wire  [2:0]  sw_first, sw_second, sector;
  integer      num_errors, n_tests, k;
  // Rows: phase samples, angle, control, expected alpha/beta, d/q, voltage alpha/beta.
  // Expected rotations follow the coarse sine table, whose quarter-turn entry is 16'h3fb1.
  logic [15:0] iu_t [0:3] = '{16'h4000, 16'h4000, 16'h4000, 16'hc000};
  logic [15:0] iv_t [0:3] = '{16'h0000, 16'h0000, 16'h0000, 16'h2000};
  logic [15:0] an_t [0:3] = '{16'h0000, 16'h4000, 16'h4000, 16'h0000};
  logic [31:0] ct_t [0:3] = '{32'h1, 32'h1, 32'h5, 32'h1};
  logic [31:0] ab_t [0:3] = '{32'h24f34000, 32'h24f34000, 32'h24f34000, 32'h0000c000};
  logic [31:0] dq_t [0:3] = '{32'h24c53fb1, 32'h3fb124c5, 32'hc04f24c5, 32'h0000c04f};
  logic [31:0] vb_t [0:3] = '{32'h00000fec, 32'hf0130000, 32'hf0130000, 32'h00000fec};

  svmfoc_datapath dut (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .adc_valid(adc_valid), .adc_iu(adc_iu), .adc_iv(adc_iv),
    .duty_u(duty_u), .duty_v(duty_v), .duty_w(duty_w), .duty_valid(duty_valid),
    .sw_first(sw_first), .sw_second(sw_second), .sector(sector));
  svmfoc_adc_model u_adc (.clk_sys(clk_sys), .rst(rst), .req(adc_req), .iu_in(iu_in),
    .iv_in(iv_in), .adc_valid(adc_valid), .adc_iu(adc_iu), .adc_iv(adc_iv));

  // Free-running system clock, 4 ns period.
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  // One APB transfer; the request is held until pready is seen at a rising edge.
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) @(posedge clk_sys);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task rchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(rd, e)
  endtask
  // Converter request; the sample reaches the datapath two cycles later.
  task adc(input logic [15:0] u, input logic [15:0] v);
    @(posedge clk_sys);
    iu_in <= u; iv_in <= v; adc_req <= 1'b1;
    @(posedge clk_sys);
    adc_req <= 1'b0;
  endtask
  // Bounded wait for the duty report, sampled mid-cycle where outputs are settled.
  task wait_done;
    for (k = 0; k < 200 && duty_valid !== 1'b1; k = k + 1) @(negedge clk_sys);
    `CHK(duty_valid, 1'b1)
  endtask
  function automatic logic [15:0] dexp(input logic f, s, input logic [15:0] t1, t2, zz);
    dexp = (f ? t1 : 16'h0) + (s ? t2 : 16'h0) + zz;
  endfunction
  // Starts one computation and checks times against the period and the duty pattern.
  task timing(input logic [31:0] c);
    apb(1'b1, `SVMFOC_A_CTRL, c | 32'h8);
    apb(1'b0, `SVMFOC_A_STAT, 32'h0);
    `CHK(rd[0], 1'b1)
    wait_done;
    apb(1'b0, `SVMFOC_A_T12, 32'h0);
    t12 = rd;
    apb(1'b0, `SVMFOC_A_T0, 32'h0);
    t0v = rd;
    `CHK(t12[15:0] + t12[31:16] + t0v[15:0], 16'h03e8)
    `CHK({sector, sw_first, sw_second}, 9'b000_100_110)
    z = c[0] ? (t0v[15:0] >> 1) : 16'h0000;
    `CHK(duty_u, dexp(sw_first[2], sw_second[2], t12[15:0], t12[31:16], z))
    `CHK(duty_v, dexp(sw_first[1], sw_second[1], t12[15:0], t12[31:16], z))
    `CHK(duty_w, dexp(sw_first[0], sw_second[0], t12[15:0], t12[31:16], z))
  endtask
  task end_of_test;
    $display("Comparisons %0d, mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Hang guard, far beyond the fewer than one thousand cycles the sequence needs.
  initial begin
    repeat (20000) @(posedge clk_sys);
    num_errors = num_errors + 1;
    end_of_test;
  end

  // Main sequence.
  initial begin
    num_errors = 0; n_tests = 0;
    rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
    pwdata = 32'h0; adc_req = 1'b0; iu_in = 16'h0; iv_in = 16'h0;
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    // Status after reset shows sector A, codes 100 and 110, and leg voltages 2, -1, -1.
    for (int i = 0; i < 14; i++)
      rchk(8'(i * 4), i == 0 ? 32'h1 : i == 1 ? 32'h0007eb40 : i == 2 ? 32'h3e8 :
        i == 3 ? 32'h100 : 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    `CHK({er, rd}, {1'b1, 32'h0})
    apb(1'b1, `SVMFOC_A_T0, 32'hffff);
    rchk(`SVMFOC_A_T0, 32'h0);
    $display("test registers done");
    apb(1'b1, `SVMFOC_A_VDQ, 32'h00001000);
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, `SVMFOC_A_ANGLE, {16'h0, an_t[i]});
      apb(1'b1, `SVMFOC_A_CTRL, ct_t[i]);
      adc(iu_t[i], iv_t[i]);
      apb(1'b1, `SVMFOC_A_CTRL, ct_t[i] | 32'h8);
      wait_done;
      rchk(`SVMFOC_A_IAB, ab_t[i]);
      rchk(`SVMFOC_A_IDQ, dq_t[i]);
      rchk(`SVMFOC_A_VAB, vb_t[i]);
    end
    $display("test transforms done");
    apb(1'b1, `SVMFOC_A_ANGLE, 32'h0);
    apb(1'b1, `SVMFOC_A_VDQ, 32'h00400080);
    timing(32'h1);
    t12s = t12;
    // Gain is 1000 * 65536 / 256; the sine terms are 78 and 63 for this vector.
    `CHK({t0v[15:0], t12}, 48'h01c2_00f6_0130)
    timing(32'h0);
    `CHK(t12, t12s)
    apb(1'b1, `SVMFOC_A_VDC, 32'h0);
    timing(32'h1);
    `CHK(t12, 32'h000003e8)
    apb(1'b1, `SVMFOC_A_VDC, 32'h100);
    $display("test timing done");
    apb(1'b1, `SVMFOC_A_CTRL, 32'h13);
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, `SVMFOC_A_POLAR, {16'h1000 + 16'(i) * 16'h2aab, 16'h1000});
      adc(16'h0, 16'h0);
      wait_done;
      `CHK(sector, 3'(i))
    end
    $display("test sectors done");
    apb(1'b1, `SVMFOC_A_CTRL, 32'h0);
    @(posedge clk_sys);
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    rchk(`SVMFOC_A_CTRL, 32'h1);
    `CHK({duty_u, duty_v, duty_w, duty_valid, sector}, 52'h0)
    $display("test reset done");
    end_of_test;
  end
endmodule // testbench
